// ---- src/mhp_pkg.sv ----
// Package: constants and carriers for the multiplexed 16-bit host port
package mhp_pkg;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned ADDR_W       = 14;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned LO_BYTE_POS  = 0;
  localparam int unsigned HI_BYTE_POS  = 8;
  localparam logic [13:0] ADDR_RESET   = 14'h0000;
  localparam logic [15:0] DATA_RESET   = 16'h0000;
  localparam int unsigned SYNC_STAGES  = 3;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // Read access time in ns; data sample cycles derived from it
  localparam int unsigned ACCESS_NS    = 60;
  localparam int unsigned ACCESS_CYC   = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    MHP_OPT_NONE   = 3'b001,
    MHP_OPT_DUALWR = 3'b010,
    MHP_OPT_BYTSEL = 3'b100
  } mhp_opt_t;

  // Synchronised host control pins
  typedef struct packed {
    logic dev_sel;
    logic addr_latch_strobe;
    logic rd_or_rw;
    logic wr_hi_or_b1;
    logic wr_lo_or_b0;
  } mhp_ctl_t;

  // Request towards the internal memory side
  typedef struct packed {
    logic        wr;
    logic [1:0]  byte_en;
    logic [13:0] addr;
    logic [15:0] data;
  } mhp_req_t;
endpackage : mhp_pkg

// ---- src/mhp_sync.sv ----
// Three-stage synchroniser for host control pins
`timescale 1ns/100ps
`default_nettype none
module mhp_sync
  import mhp_pkg::*;
#(
  parameter int unsigned W = 5
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1, s2, s3, lvl;
  logic [W-1:0] next_lvl;

  // **************************************************
  // Agreement filter
  // **************************************************
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // First stage feeds only the second, so no glitch reaches logic
      always_comb begin
        next_lvl[g] = (s2[g] == s3[g]) ? s3[g] : lvl[g];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1  <= '0;
      s2  <= '0;
      s3  <= '0;
      lvl <= '0;
    end else begin
      s1  <= async_in;
      s2  <= s1;
      s3  <= s2;
      lvl <= next_lvl;
    end
  end

  assign level_out = lvl;
endmodule : mhp_sync
`default_nettype wire

// ---- src/mhp_port.sv ----
// Multiplexed 16-bit host port, dual write strobe and byte select options
// Summary of operation
// RULE1 - Straps 2,3 high, 1 low: dual-write option
// RULE2 - All three straps high: byte-select option
// RULE3 - Sixteen data lines; low fourteen carry address
// RULE4 - Dual-write: float bus when unselected or unread
// RULE5 - Host reads: select, address, latch, release, read
// RULE6 - Drive bus during read strobe, release after
// RULE7 - Every read returns a full sixteen-bit word
// RULE8 - Dual-write: store only strobed bytes
// RULE9 - Host never overlaps read/latch with writes
// RULE10 - Dual-write: latched address kept for repeats
// RULE11 - Select high reads, low writes, under strobes
// RULE12 - Byte-select: float unless selected, read, strobed
// RULE13 - Host never overlaps latch with byte strobes
// RULE14 - Byte-select read drives until both strobes low
// RULE15 - Host byte-select read sequence with released bus
// RULE16 - Byte-select write stores only strobed bytes
// RULE17 - Byte-select: latched address kept for repeats
// RULE18 - Unused device select tied high
// RULE19 - Joined write strobes write whole words
// RULE20 - Address captured on latch strobe falling edge
`timescale 1ns/100ps
`default_nettype none
module mhp_port
  import mhp_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        bus_option_strap_one_in,
  input  wire logic        bus_option_strap_two_in,
  input  wire logic        bus_option_strap_three_in,
  input  wire logic        dev_sel_in,
  input  wire logic        addr_latch_strobe_in,
  input  wire logic        rd_or_rw_in,
  input  wire logic        high_byte_write_strobe_in,
  input  wire logic        low_byte_write_strobe_in,
  input  wire logic [15:0] ad_in,
  output logic      [15:0] ad_out,
  output logic      [15:0] ad_oe_out,
  output logic             mem_req_out,
  output logic             mem_wr_out,
  output logic      [1:0]  mem_byte_en_out,
  output logic      [13:0] mem_addr_out,
  output logic      [15:0] mem_wdata_out,
  input  wire logic [15:0] mem_rdata_in,
  output logic      [2:0]  bus_option_out
);
  // High_byte/low_byte write strobes double as byte_one/byte_zero strobes
  mhp_ctl_t ctl, ctl_d;
  logic [15:0] ad_s1, ad_mid1, ad_mid2, ad_s2;

  mhp_sync #(.W(5)) u_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .async_in    ({dev_sel_in, addr_latch_strobe_in, rd_or_rw_in,
                   high_byte_write_strobe_in, low_byte_write_strobe_in}),
    .level_out   (ctl)
  );

  // **************************************************
  // Option strap capture
  // **************************************************
  // Straps are caught once after reset release, never under reset
  mhp_opt_t opt, next_opt;
  logic     strap_done, next_strap_done;

  always_comb begin
    next_opt        = opt;
    next_strap_done = 1'b1;
    if (!strap_done) begin
      if (bus_option_strap_two_in && bus_option_strap_three_in)
        next_opt = bus_option_strap_one_in ? MHP_OPT_BYTSEL : MHP_OPT_DUALWR; // [RULE1] [RULE2]
      else
        next_opt = MHP_OPT_NONE;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      opt        <= MHP_OPT_NONE;
      strap_done <= 1'b0;
    end else begin
      opt        <= next_opt;
      strap_done <= next_strap_done;
    end
  end

  assign bus_option_out = opt;

  // **************************************************
  // Strobe decode
  // **************************************************
  // Bus data delayed to match control synchroniser latency
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ad_s1   <= DATA_RESET;
      ad_mid1 <= DATA_RESET;
      ad_mid2 <= DATA_RESET;
      ad_s2   <= DATA_RESET;
      ctl_d   <= '0;
    end else begin
      // Four stages, as three sync flops plus the filter register
      ad_s1   <= ad_in;
      ad_mid1 <= ad_s1;
      ad_mid2 <= ad_mid1;
      ad_s2   <= ad_mid2;
      ctl_d   <= ctl;
    end
  end

  logic any_wr, read_act, wr_fall;
  logic [1:0] wr_en_now;

  always_comb begin
    any_wr    = 1'b0;
    read_act  = 1'b0;
    wr_en_now = 2'b00;
    unique case (opt)
      MHP_OPT_DUALWR: begin
        read_act  = ctl.dev_sel && ctl.rd_or_rw;                        // [RULE4] [RULE6]
        wr_en_now = {ctl.wr_hi_or_b1, ctl.wr_lo_or_b0};                 // [RULE8]
        any_wr    = ctl.dev_sel && (wr_en_now != 2'b00);
      end
      MHP_OPT_BYTSEL: begin
        read_act  = ctl.dev_sel && ctl.rd_or_rw
                    && (ctl.wr_hi_or_b1 || ctl.wr_lo_or_b0);            // [RULE11] [RULE12] [RULE14]
        wr_en_now = ctl.rd_or_rw ? 2'b00 : {ctl.wr_hi_or_b1, ctl.wr_lo_or_b0}; // [RULE11] [RULE16]
        any_wr    = ctl.dev_sel && (wr_en_now != 2'b00);
      end
      default: begin
        read_act  = 1'b0;
      end
    endcase
  end

  // Write commits on strobe release so data is settled; bytes accumulate
  logic [1:0] wr_bytes, next_wr_bytes;
  assign wr_fall = (wr_bytes != 2'b00) && !any_wr;

  always_comb begin
    next_wr_bytes = any_wr ? (wr_bytes | wr_en_now) : 2'b00;
  end

  // **************************************************
  // Address latch and request
  // **************************************************
  logic [13:0] addr, next_addr;
  logic [15:0] wdata, next_wdata;
  logic        req, next_req, wr, next_wr;
  logic [1:0]  ben, next_ben;
  logic        rd_prev, next_rd_prev;

  always_comb begin
    next_addr    = addr;
    next_wdata   = wdata;
    next_req     = 1'b0;
    next_wr      = wr;
    next_ben     = ben;
    next_rd_prev = read_act;
    // Capture on falling edge; held for repeated strobes
    if (ctl_d.addr_latch_strobe && !ctl.addr_latch_strobe && ctl.dev_sel)
      next_addr = ad_s2[ADDR_W-1:0];                                    // [RULE3] [RULE20] [RULE10] [RULE17]
    if (any_wr) begin
      if (wr_en_now[0])
        next_wdata[LO_BYTE_POS +: BYTE_W] = ad_s2[LO_BYTE_POS +: BYTE_W]; // [RULE8] [RULE16]
      if (wr_en_now[1])
        next_wdata[HI_BYTE_POS +: BYTE_W] = ad_s2[HI_BYTE_POS +: BYTE_W];
    end
    if (wr_fall) begin
      next_req = 1'b1;
      next_wr  = 1'b1;
      next_ben = wr_bytes;                                              // [RULE8] [RULE19]
    end else if (read_act && !rd_prev) begin
      next_req = 1'b1;
      next_wr  = 1'b0;
      next_ben = 2'b11;                                                 // [RULE7]
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr     <= ADDR_RESET;
      wdata    <= DATA_RESET;
      req      <= 1'b0;
      wr       <= 1'b0;
      ben      <= 2'b00;
      rd_prev  <= 1'b0;
      wr_bytes <= 2'b00;
    end else begin
      addr     <= next_addr;
      wdata    <= next_wdata;
      req      <= next_req;
      wr       <= next_wr;
      ben      <= next_ben;
      rd_prev  <= next_rd_prev;
      wr_bytes <= next_wr_bytes;
    end
  end

  assign mem_req_out     = req;
  assign mem_wr_out      = wr;
  assign mem_byte_en_out = ben;
  assign mem_addr_out    = addr;
  assign mem_wdata_out   = wdata;

  // **************************************************
  // Read data drive
  // **************************************************
  // Data is indeterminate until the access time elapses; we show zero
  logic [15:0] rdata, next_rdata;
  logic [2:0]  acc_cnt, next_acc_cnt;
  logic        oe, next_oe;

  always_comb begin
    next_oe      = read_act;                                            // [RULE4] [RULE6] [RULE12] [RULE14]
    next_rdata   = rdata;
    next_acc_cnt = acc_cnt;
    if (!read_act) begin
      next_acc_cnt = 3'd0;
      next_rdata   = DATA_RESET;
    end else if (acc_cnt < 3'(ACCESS_CYC)) begin
      next_acc_cnt = acc_cnt + 3'd1;
    end else begin
      next_rdata   = mem_rdata_in;                                      // [RULE7]
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata   <= DATA_RESET;
      acc_cnt <= 3'd0;
      oe      <= 1'b0;
    end else begin
      rdata   <= next_rdata;
      acc_cnt <= next_acc_cnt;
      oe      <= next_oe;
    end
  end

  assign ad_out    = rdata;
  assign ad_oe_out = {DATA_W{oe}};

  // **************************************************
  // Checks
  // **************************************************
  sequence s_latch_fall;
    ctl_d.addr_latch_strobe && !ctl.addr_latch_strobe && ctl.dev_sel;
  endsequence

  a_bus_float_unsel: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE4] [RULE12]
    !ctl.dev_sel |=> !ad_oe_out[0]) else $error("Bus driven while unselected");
  a_read_drive: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE6] [RULE14]
    read_act |=> ad_oe_out == 16'hffff) else $error("Read not driving bus");
  a_read_release: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE6]
    $fell(read_act) |-> ##1 !ad_oe_out[15]) else $error("Bus not released");
  a_bytsel_wr_float: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE12]
    (opt == MHP_OPT_BYTSEL && !ctl.rd_or_rw) |=> !oe) else $error("Drive during write");
  a_addr_capture: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE20]
    s_latch_fall |=> mem_addr_out == $past(ad_s2[13:0])) else $error("Address not captured");
  a_addr_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE10] [RULE17]
    !(ctl_d.addr_latch_strobe && !ctl.addr_latch_strobe) |=> $stable(mem_addr_out))
    else $error("Address changed without latch");
  a_read_full_word: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE7]
    (mem_req_out && !mem_wr_out) |-> mem_byte_en_out == 2'b11) else $error("Partial read");
  a_write_bytes: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE8] [RULE16]
    wr_fall |=> mem_req_out && mem_wr_out && mem_byte_en_out == $past(wr_bytes))
    else $error("Write bytes wrong");
  a_strap_decode: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE1]
    $rose(strap_done) |-> (opt == MHP_OPT_DUALWR)
      == (bus_option_strap_two_in && bus_option_strap_three_in && !bus_option_strap_one_in))
    else $error("Dual-write strap decode wrong");
  a_strap_bytsel: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE2]
    $rose(strap_done) |-> (opt == MHP_OPT_BYTSEL)
      == (bus_option_strap_one_in && bus_option_strap_two_in && bus_option_strap_three_in))
    else $error("Byte-select strap decode wrong");
  a_strap_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE1] [RULE2]
    strap_done |=> $stable(opt)) else $error("Option changed after capture");
endmodule : mhp_port
`default_nettype wire

// ---- test/mhp_host_model.sv ----
// Host bus master model that drives the multiplexed port pins
`timescale 1ns/100ps
`default_nettype none
module mhp_host_model
  import mhp_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic [15:0] dev_ad_in,
  input  wire logic [15:0] dev_oe_in,
  output logic             sel_out,
  output logic             al_out,
  output logic             rw_out,
  output logic      [1:0]  stb_out,
  output logic      [15:0] ad_out
);
  logic        drv  = 1'b0;
  logic [15:0] val  = 16'h0000;
  logic [15:0] last = 16'h0000;

  initial begin
    {sel_out, al_out, rw_out, stb_out} = 5'h10;
  end

  // Released lines toggle, so a stale word never passes for read data
  // Unknown start level is cleared, else the toggle never begins
  always @(posedge core_clk_in) last <= (^ad_out === 1'bx) ? 16'h0000 : ad_out;
  assign ad_out = (dev_oe_in & dev_ad_in) | (~dev_oe_in & (drv ? val : ~last));

  task automatic hold(input int n);
    repeat (n) @(posedge core_clk_in);
    #2;
  endtask : hold

  // Address, latch pulse, then bus released
  task automatic latch(input logic [13:0] a);
    val = {2'b00, a};
    drv = 1'b1;
    hold(2);
    al_out = 1'b1;
    hold(8);
    al_out = 1'b0;
    hold(8);
    drv = 1'b0;
    hold(2);
  endtask : latch

  // Direction first, strobes later, never beside the latch
  task automatic access(input logic [2:0] ctl, input logic [15:0] d,
                        output logic [15:0] seen, output logic [15:0] oe);
    rw_out = ctl[2];
    val = d;
    drv = ~ctl[2];
    hold(6);
    stb_out = ctl[1:0];
    hold(14);
    seen = ad_out;
    oe = dev_oe_in;
    {rw_out, stb_out} = 3'h0;
    hold(4);
    drv = 1'b0;
    hold(6);
  endtask : access
endmodule : mhp_host_model
`default_nettype wire

// ---- test/mhp_port_tb.sv ----
// Self-checking bench for the multiplexed host port
`timescale 1ns/100ps
`default_nettype none
module mhp_port_tb;
  import mhp_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] strap = 3'h0;
  logic sel, al, rw;
  logic [1:0] stb;
  logic [15:0] ad_in, ad_out, ad_oe_out, mem_wdata_out, mem_rdata_in, seen, oe, d;
  logic mem_req_out, mem_wr_out;
  logic [1:0] mem_byte_en_out;
  logic [13:0] mem_addr_out, a;
  logic [2:0] bus_option_out;
  mhp_req_t exp_q[$];
  mhp_req_t e;
  int n_errors = 0;
  int num_checks = 0;

  always #10 core_clk_in = ~core_clk_in;
  // Memory stand-in: word is a fixed scramble of its address
  assign mem_rdata_in = {2'b11, mem_addr_out} ^ 16'h0f0f;

  mhp_port u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .bus_option_strap_one_in(strap[0]),
    .bus_option_strap_two_in(strap[1]), .bus_option_strap_three_in(strap[2]), .dev_sel_in(sel),
    .addr_latch_strobe_in(al), .rd_or_rw_in(rw), .high_byte_write_strobe_in(stb[1]),
    .low_byte_write_strobe_in(stb[0]), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_out(ad_oe_out),
    .mem_req_out(mem_req_out), .mem_wr_out(mem_wr_out), .mem_byte_en_out(mem_byte_en_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in),
    .bus_option_out(bus_option_out));
  mhp_host_model u_host (.core_clk_in(core_clk_in), .dev_ad_in(ad_out), .dev_oe_in(ad_oe_out),
    .sel_out(sel), .al_out(al), .rw_out(rw), .stb_out(stb), .ad_out(ad_in));

  // ********************
  // Checking
  // ********************
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    num_checks++;
    if (s !== x) begin
      n_errors++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // Sampled mid-cycle, away from the edge that launches the pulse
  always @(negedge core_clk_in) begin
    if (mem_req_out === 1'b1) begin
      if (exp_q.size() == 0) chk(16'h0001, 16'h0000);
      else begin
        e = exp_q.pop_front();
        chk({15'h0000, mem_wr_out}, {15'h0000, e.wr});
        chk({14'h0000, mem_byte_en_out}, {14'h0000, e.byte_en});
        chk({2'b00, mem_addr_out}, {2'b00, e.addr});
        if (e.wr) chk(mem_wdata_out & {{8{e.byte_en[1]}}, {8{e.byte_en[0]}}},
                      e.data & {{8{e.byte_en[1]}}, {8{e.byte_en[0]}}});
      end
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_errors++;
    tally_and_finish();
  end

  // ********************
  // Stimulus
  // ********************
  task automatic do_reset(input logic [2:0] s);
    rst_in = 1'b1;
    strap = s;
    repeat (20) @(posedge core_clk_in);
    #2;
    rst_in = 1'b0;
    u_host.hold(4);
  endtask : do_reset

  task automatic rd_op(input logic [2:0] ctl, input logic x);
    if (x) exp_q.push_back(mhp_req_t'({1'b0, 2'b11, a, 16'h0000}));
    u_host.access(ctl, 16'h0000, seen, oe);
    chk(oe, {16{x}});
    if (x) chk(seen, {2'b11, a} ^ 16'h0f0f);
    chk(ad_oe_out, 16'h0000);
  endtask : rd_op

  task automatic wr_op(input logic [2:0] ctl);
    d = 16'($urandom);
    exp_q.push_back(mhp_req_t'({1'b1, ctl[1:0], a, d}));
    u_host.access(ctl, d, seen, oe);
    chk(oe, 16'h0000);
  endtask : wr_op

  initial begin
    void'($urandom(32'hbed6000f));
    do_reset(3'h6);
    chk({13'h0000, bus_option_out}, 16'h0002);
    a = 14'($urandom);
    u_host.latch(a);
    rd_op(3'h4, 1'b1);
    rd_op(3'h4, 1'b1);
    for (int i = 1; i < 4; i++) wr_op({1'b0, 2'(i)});
    u_host.sel_out = 1'b0;
    rd_op(3'h4, 1'b0);
    u_host.sel_out = 1'b1;
    a = 14'h3fff;
    u_host.latch(a);
    rd_op(3'h4, 1'b1);
    do_reset(3'h7);
    chk({13'h0000, bus_option_out}, 16'h0004);
    a = 14'($urandom);
    u_host.latch(a);
    for (int i = 5; i < 8; i++) rd_op(3'(i), 1'b1);
    rd_op(3'h4, 1'b0);
    for (int i = 1; i < 4; i++) wr_op({1'b0, 2'(i)});
    u_host.sel_out = 1'b0;
    rd_op(3'h7, 1'b0);
    u_host.sel_out = 1'b1;
    do_reset(3'h0);
    chk({13'h0000, bus_option_out}, 16'h0001);
    u_host.latch(a);
    rd_op(3'h4, 1'b0);
    u_host.hold(10);
    chk(16'(exp_q.size()), 16'h0000);
    tally_and_finish();
  end
endmodule : mhp_port_tb
`default_nettype wire
